// *** hdl/fcps_defines.vh ***
`ifndef FCPS_DEFINES_VH
`define FCPS_DEFINES_VH
// register byte addresses on the wishbone slave
`define FCPS_ADR_CONFIG     6'h00
`define FCPS_ADR_PROT       6'h04
`define FCPS_ADR_STATUS     6'h08
`define FCPS_ADR_COMMAND    6'h0c
`define FCPS_ADR_DIVIDER    6'h10
`define FCPS_ADR_SECURITY   6'h14
`define FCPS_ADR_KEY        6'h18
// field positions
`define FCPS_CFG_KEYWEN     5
`define FCPS_ST_CBEF        7
`define FCPS_ST_CCF         6
`define FCPS_ST_PVIOL       5
`define FCPS_ST_ACCERR      4
`define FCPS_ST_BLANK       2
`define FCPS_PROT_DIS       0
// command codes
`define FCPS_CMD_BLANK      8'h05
`define FCPS_CMD_BYTE       8'h20
`define FCPS_CMD_BURST      8'h25
`define FCPS_CMD_PAGE       8'h40
`define FCPS_CMD_MASS       8'h41
// security codes
`define FCPS_SEC_UNSECURE   2'h2
`define FCPS_SEC_SECURE     2'h3
// key window and array geometry
`define FCPS_KEY_BASE       16'hffb0
`define FCPS_KEY_TOP        16'hffb7
`define FCPS_FLASH_BASE     16'hf000
`define FCPS_PAGE_BYTES     16'h0200
`define FCPS_FPS_STEP       16'h0200
// array operation time in flash clock pulses
`define FCPS_OP_PULSES      8'h04
`endif

// *** hdl/fcps_flash_ctrl.v ***
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "fcps_defines.vh"
module fcps_flash_ctrl (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [5:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  nonvolatile_protection_byte,
  input  wire [63:0] backdoor_key_value,
  input  wire        debug_prot_we,
  input  wire [7:0]  debug_prot_data,
  input  wire        stop_request,
  input  wire        array_blank,
  output reg         array_busy,
  output reg  [7:0]  array_command,
  output reg  [15:0] array_addr,
  output reg  [7:0]  array_data,
  output reg  [1:0]  security_state_code
);
  // one-hot sequencer states: idle waits for a launch, addr hands the
  // buffer to the array, run counts flash clock pulses
  localparam ST_IDLE = 3'b001;
  localparam ST_ADDR = 3'b010;
  localparam ST_RUN  = 3'b100;

  // software visible registers
  reg  [7:0]  flash_config;
  reg  [7:0]  protection_register;
  reg  [7:0]  command_register;
  reg  [7:0]  clock_divider_register;
  reg         divider_written;

  // status flags
  reg         buffer_empty_flag;
  reg         protection_violation_flag;
  reg         access_error_flag;
  reg         blank_flag;

  // sequencer state and the array write waiting for a launch
  reg  [2:0]  state;
  reg  [15:0] pend_addr;
  reg  [7:0]  pend_data;
  reg         pend_valid;

  // one-deep command buffer, filled at launch, emptied into the array
  reg         buf_valid;
  reg  [7:0]  buf_cmd;
  reg  [15:0] buf_addr;
  reg  [7:0]  buf_data;
  reg  [7:0]  run_cnt;

  // comparison key capture
  reg  [63:0] key_shift;
  reg  [3:0]  key_count;

  // reset load, flash clock divider and last array port address
  reg         prot_loaded;
  reg  [7:0]  scale_cnt;
  reg  [5:0]  div_cnt;
  reg  [15:0] win_addr;

  // bus requests are taken only while ack is low, so a held cycle acts once;
  // writes without byte lane 0 are acknowledged but change nothing
  wire wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  wire rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  wire [7:0] wdat = wb_dat_i[7:0];
  wire prot_disabled = protection_register[`FCPS_PROT_DIS];
  wire command_complete_flag = buffer_empty_flag & (state == ST_IDLE);

  // status byte as software reads it; bits 3, 1 and 0 read zero
  wire [7:0] status_byte = {
    buffer_empty_flag,
    command_complete_flag,
    protection_violation_flag,
    access_error_flag,
    1'b0,
    blank_flag,
    2'b00
  };

  // lowest protected byte address for a protection value; each step of the
  // select field moves the floor by one 512-byte page
  function [15:0] prot_floor;
    input [7:0] p;
    begin
      prot_floor = `FCPS_FLASH_BASE + {p[7:1], 9'h000} + `FCPS_FPS_STEP;
    end
  endfunction

  // command code legality: only the five defined codes may reach the array
  function cmd_legal;
    input [7:0] c;
    begin
      cmd_legal = (c == `FCPS_CMD_BLANK) | (c == `FCPS_CMD_BYTE) |
                  (c == `FCPS_CMD_BURST) | (c == `FCPS_CMD_PAGE) |
                  (c == `FCPS_CMD_MASS);
    end
  endfunction

  // the address window written through the key register data word; the
  // window test uses the address carried in the data, since the bus
  // address only selects the port
  wire [15:0] key_adr = wb_dat_i[23:8];
  wire key_window = (key_adr >= `FCPS_KEY_BASE) && (key_adr <= `FCPS_KEY_TOP);
  wire arr_write = wr_req && (wb_adr_i == `FCPS_ADR_KEY);

  // protection check on the pending target: mass erase touches the
  // protected block whenever protection is on, and a page erase is
  // refused if any byte of its page lies at or above the floor
  wire hits_prot = ~prot_disabled &&
                   ((command_register == `FCPS_CMD_MASS) ||
                    (pend_addr >= prot_floor(protection_register)) ||
                    ((command_register == `FCPS_CMD_PAGE) &&
                     (pend_addr + `FCPS_PAGE_BYTES > prot_floor(protection_register))));
  wire is_program = (command_register == `FCPS_CMD_BYTE) |
                    (command_register == `FCPS_CMD_BURST) |
                    (command_register == `FCPS_CMD_PAGE) |
                    (command_register == `FCPS_CMD_MASS);
  wire launch_wr = wr_req && (wb_adr_i == `FCPS_ADR_STATUS) && wdat[`FCPS_ST_CBEF] &&
                   buffer_empty_flag;

  // launch decisions: errors already standing block everything; a missing
  // array write, an unknown code, an unset divider on a program or erase code, or a
  // busy array not chaining a burst onto a burst is an access error; only when none of those hold does the protection check
  // get to raise a violation, so one launch never sets both flags at once
  wire launch_ok   = launch_wr && ~access_error_flag && ~protection_violation_flag &&
                     pend_valid && cmd_legal(command_register) &&
                     ~(is_program && ~divider_written) && ~hits_prot &&
                     ((state == ST_IDLE) || (command_register == `FCPS_CMD_BURST &&
                      array_command == `FCPS_CMD_BURST));
  wire launch_acc  = launch_wr && ~access_error_flag && ~protection_violation_flag &&
                     (~pend_valid || ~cmd_legal(command_register) ||
                      (is_program && ~divider_written) ||
                      ((state != ST_IDLE) && ~(command_register == `FCPS_CMD_BURST &&
                       array_command == `FCPS_CMD_BURST)));
  wire launch_viol = launch_wr && ~access_error_flag && ~protection_violation_flag &&
                     ~launch_acc && hits_prot;

  // flash clock pulse from the divider register; bit 6 adds a divide by
  // eight ahead of the six-bit divider, so the pulse comes every (div + 1)
  // or 8 * (div + 1) bus cycles; array steps count these pulses
  wire fclk_tick = (div_cnt == clock_divider_register[5:0]) &&
                   (~clock_divider_register[6] || scale_cnt[2:0] == 3'h7);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt   <= 6'h00;
      scale_cnt <= 8'h00;
    end else begin
      scale_cnt <= scale_cnt + 8'h01;
      if (~clock_divider_register[6] || scale_cnt[2:0] == 3'h7) begin
        div_cnt <= fclk_tick ? 6'h00 : div_cnt + 6'h01;
      end
    end
  end

  // software registers, protection and key capture
  // the protection copy happens on the first edge after reset, so only a read
  // answered on that edge sees 8'h00 instead of the nonvolatile byte; after that the
  // debug port outranks software, and a grow-only check guards software
  // writes while protection is on
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_config           <= 8'h00;
      protection_register    <= 8'h00;
      prot_loaded            <= 1'b0;
      command_register       <= 8'h00;
      clock_divider_register <= 8'h00;
      divider_written        <= 1'b0;
      pend_valid             <= 1'b0;
      pend_addr              <= 16'h0000;
      pend_data              <= 8'h00;
      key_shift              <= 64'h0;
      key_count              <= 4'h0;
      win_addr               <= 16'h0000;
    end else begin
      if (!prot_loaded) begin
        protection_register <= nonvolatile_protection_byte;
        prot_loaded         <= 1'b1;
      end else if (debug_prot_we) begin
        protection_register <= debug_prot_data;
      end else if (wr_req && wb_adr_i == `FCPS_ADR_PROT) begin
        if (prot_disabled) begin
          protection_register <= wdat;
        end else if (prot_floor(wdat) < prot_floor(protection_register)) begin
          protection_register <= {wdat[7:1], 1'b0};
        end
      end
      if (wr_req && wb_adr_i == `FCPS_ADR_CONFIG) begin
        flash_config <= wdat & 8'h20;
      end
      // the divider takes one write only, so a runaway program cannot
      // retune the flash clock in the middle of an operation
      if (wr_req && wb_adr_i == `FCPS_ADR_DIVIDER && !divider_written) begin
        clock_divider_register <= wdat & 8'h7f;
        divider_written        <= 1'b1;
      end
      // the code cannot change under a buffered burst
      if (wr_req && wb_adr_i == `FCPS_ADR_COMMAND && buffer_empty_flag) begin
        command_register <= wdat;
      end
      // the array port doubles as the key port: with key writes on, window
      // bytes shift into the comparison key and never reach the command
      // path; otherwise, with the command buffer empty, the byte and address wait for a launch
      if (arr_write) begin
        win_addr <= key_adr;
        if (flash_config[`FCPS_CFG_KEYWEN] && key_window) begin
          key_shift <= {key_shift[55:0], wdat};
          key_count <= (key_count == 4'h8) ? 4'h1 : key_count + 4'h1;
        end else if (buffer_empty_flag) begin
          pend_addr  <= key_adr;
          pend_data  <= wdat;
          pend_valid <= 1'b1;
        end
      end
      if (launch_wr) begin
        pend_valid <= 1'b0;
      end
      if (key_count == 4'h8) begin
        key_count <= 4'h0;
      end
    end
  end

  // status flags, command buffer and array sequencing
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_empty_flag         <= 1'b1;
      protection_violation_flag <= 1'b0;
      access_error_flag         <= 1'b0;
      blank_flag                <= 1'b0;
      state                     <= ST_IDLE;
      buf_valid                 <= 1'b0;
      buf_cmd                   <= 8'h00;
      buf_addr                  <= 16'h0000;
      buf_data                  <= 8'h00;
      run_cnt                   <= 8'h00;
      array_busy                <= 1'b0;
      array_command             <= 8'h00;
      array_addr                <= 16'h0000;
      array_data                <= 8'h00;
      security_state_code       <= `FCPS_SEC_SECURE;
    end else begin
      // write 1 clears; a new event in the same cycle wins, because the
      // set assignments below come later in the process and override
      // write 1 clears; a new event in the same cycle wins
      if (wr_req && wb_adr_i == `FCPS_ADR_STATUS) begin
        if (wdat[`FCPS_ST_PVIOL]) protection_violation_flag <= 1'b0;
        if (wdat[`FCPS_ST_ACCERR]) access_error_flag <= 1'b0;
      end
      if (launch_viol) begin
        protection_violation_flag <= 1'b1;
      end
      if (launch_acc || (stop_request && state != ST_IDLE)) begin
        access_error_flag <= 1'b1;
      end
      if (arr_write && ~buffer_empty_flag) begin
        access_error_flag <= 1'b1;
      end
      // eight key bytes in a row are compared once; a match leaves the part
      // unsecured until the next reset
      if (key_count == 4'h8 && key_shift == backdoor_key_value) begin
        security_state_code <= `FCPS_SEC_UNSECURE;
      end
      if (launch_ok) begin
        blank_flag        <= 1'b0;
        buffer_empty_flag <= 1'b0;
        buf_valid         <= 1'b1;
        buf_cmd           <= command_register;
        buf_addr          <= pend_addr;
        buf_data          <= pend_data;
      end
      case (state)
        ST_IDLE: begin
          if (buf_valid) begin
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // buffer moves into the array, freeing it for a burst
          array_busy        <= 1'b1;
          array_command     <= buf_cmd;
          array_addr        <= buf_addr;
          array_data        <= buf_data;
          buf_valid         <= 1'b0;
          buffer_empty_flag <= 1'b1;
          run_cnt           <= `FCPS_OP_PULSES;
          state             <= ST_RUN;
        end
        ST_RUN: begin
          // stop entry abandons the operation at once; the access error is
          // raised above, so software learns the array state is unknown
          if (stop_request) begin
            array_busy <= 1'b0;
            state      <= ST_IDLE;
          end else if (fclk_tick) begin
            if (run_cnt == 8'h01) begin
              array_busy <= 1'b0;
              state      <= ST_IDLE;
              if (array_command == `FCPS_CMD_BLANK && array_blank) begin
                blank_flag          <= 1'b1;
                security_state_code <= `FCPS_SEC_UNSECURE;
              end
            end else begin
              run_cnt <= run_cnt - 8'h01;
            end
          end
          // a burst byte already waiting goes straight into the array without
          // passing through idle, so the complete flag stays low between bytes
          if (buf_valid && run_cnt == 8'h01 && fclk_tick) begin
            state <= ST_ADDR; // burst continues back to back
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (launch_ok && state == ST_IDLE) begin
        state <= ST_ADDR;
      end
    end
  end

  // wishbone answer, one wait-free cycle after the request
  // every request, mapped or not, is answered on the next edge; read data
  // is registered with ack and cleared otherwise, so it is zero between
  // reads and stands only in the ack cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= (wr_req | rd_req | (wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o));
      wb_dat_o <= 32'h0;
      if (rd_req) begin
        case (wb_adr_i)
          `FCPS_ADR_CONFIG:   wb_dat_o <= {24'h0, flash_config};
          `FCPS_ADR_PROT:     wb_dat_o <= {24'h0, protection_register};
          `FCPS_ADR_STATUS:   wb_dat_o <= {24'h0, status_byte};
          `FCPS_ADR_COMMAND:  wb_dat_o <= {24'h0, command_register};
          `FCPS_ADR_DIVIDER:  wb_dat_o <= {24'h0, divider_written,
                                           clock_divider_register[6:0]};
          `FCPS_ADR_SECURITY: wb_dat_o <= {30'h0, security_state_code};
          `FCPS_ADR_KEY:      wb_dat_o <= {8'h0, win_addr, 8'h00};
          default:            wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule // fcps_flash_ctrl

// *** dv/fcps_flash_ctrl_monitor.sv ***
`timescale 1ns/100ps
`include "fcps_defines.vh"
module fcps_flash_ctrl_monitor (
  input wire        clk,
  input wire        rst_n,
  input wire [5:0]  wb_adr_i,
  input wire        wb_we_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        stop_request,
  input wire        array_busy,
  input wire [7:0]  array_command,
  input wire [15:0] array_addr,
  input wire [1:0]  security_state_code
);
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // status read answered on this edge
  wire rd_st = wb_ack_o && !wb_we_i && (wb_adr_i == `FCPS_ADR_STATUS);

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered on the next edge");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_BYTE: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  AST_SEC_ONEWAY: assert property ($changed(security_state_code) |-> security_state_code == `FCPS_SEC_UNSECURE)
    else $error("security code moved to a value other than unsecured");
  AST_CMD_LEGAL: assert property ($rose(array_busy) |-> array_command inside {`FCPS_CMD_BLANK, `FCPS_CMD_BYTE, `FCPS_CMD_BURST, `FCPS_CMD_PAGE, `FCPS_CMD_MASS})
    else $error("array started with an undefined command");
  AST_BUSY_NO_CCF: assert property (rd_st && $past(array_busy) && array_busy |-> !wb_dat_o[`FCPS_ST_CCF])
    else $error("complete flag read high during an array operation");
  AST_STOP_ABORT: assert property (stop_request && array_busy |-> ##[1:8] !array_busy)
    else $error("stop entry did not abort the operation");
  AST_NONBURST_ADDR: assert property (array_busy && $past(array_busy) && array_command != `FCPS_CMD_BURST |-> $stable(array_addr))
    else $error("address moved during a single operation");

  COV_LAUNCH: cover property ($rose(array_busy));
  COV_UNSECURE: cover property ($changed(security_state_code));
  COV_STOP: cover property (stop_request && array_busy);
endmodule // fcps_flash_ctrl_monitor

bind fcps_flash_ctrl fcps_flash_ctrl_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_request(stop_request),
  .array_busy(array_busy), .array_command(array_command), .array_addr(array_addr),
  .security_state_code(security_state_code));

// *** dv/fcps_flash_ctrl_tb.sv ***
`timescale 1ns/100ps
`include "fcps_defines.vh"
module fcps_flash_ctrl_tb;
  logic        clk, rst_n, we, cyc, stb, ack, dbg_we, stop, blank, busy;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  sel;
  logic [7:0]  nvp, dbg_d, acmd, adat, last_cmd;
  logic [15:0] aaddr;
  logic [1:0]  sec;
  int          n_errors, cmp_count, cyc_cnt, n_busy, n0, i;
  typedef struct {logic [7:0] code; logic bl; logic [7:0] st; logic [1:0] sc;} fcps_row_t;
  fcps_row_t   rows [7];

  // key value is arbitrary
  fcps_flash_ctrl DUT (.clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .nonvolatile_protection_byte(nvp), .backdoor_key_value(64'h0123456789abcdef),
    .debug_prot_we(dbg_we), .debug_prot_data(dbg_d), .stop_request(stop), .array_blank(blank),
    .array_busy(busy), .array_command(acmd), .array_addr(aaddr), .array_data(adat),
    .security_state_code(sec));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // run length watchdog
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors++;
      end_sim;
    end
  end
  // count array starts and keep the last command seen
  always @(posedge busy) n_busy++;
  always @(posedge clk) if (busy) last_cmd <= acmd;

  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (ack !== 1'b1) n_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // array write, command code, then launch
  task launch(input logic [7:0] code, input logic [15:0] a);
    wb(`FCPS_ADR_KEY, 1'b1, {8'h00, a, 8'h5a});
    wb(`FCPS_ADR_COMMAND, 1'b1, {24'h0, code});
    wb(`FCPS_ADR_STATUS, 1'b1, 32'h80);
  endtask
  // poll status until complete flag is set
  task wait_done;
    repeat (40) begin
      wb(`FCPS_ADR_STATUS, 1'b0, 32'h0);
      if (q[`FCPS_ST_CCF] === 1'b1) break;
    end
  endtask

  initial begin
    rows = '{'{`FCPS_CMD_BYTE, 1'b0, 8'hc0, 2'h3}, '{`FCPS_CMD_BURST, 1'b0, 8'hc0, 2'h3},
             '{`FCPS_CMD_PAGE, 1'b0, 8'hc0, 2'h3}, '{`FCPS_CMD_MASS, 1'b0, 8'hc0, 2'h3},
             '{`FCPS_CMD_BLANK, 1'b0, 8'hc0, 2'h3}, '{`FCPS_CMD_BLANK, 1'b1, 8'hc4, 2'h2},
             '{8'h33, 1'b1, 8'hd4, 2'h2}};
    rst_n = 1'b0;
    {cyc, stb, we, dbg_we, stop, blank} = 6'h0;
    adr = 6'h0;
    wdat = 32'h0;
    sel = 4'hf;
    nvp = 8'h06;
    dbg_d = 8'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(sec, 2'h3);
    wb(`FCPS_ADR_PROT, 1'b0, 32'h0);
    chk(q, 32'h06);
    wb(`FCPS_ADR_STATUS, 1'b0, 32'h0);
    chk(q & 32'hf4, 32'hc0);
    // launch before divider set, then refused launches while error stands
    n0 = n_busy;
    launch(`FCPS_CMD_BYTE, 16'hf000);
    wait_done;
    chk(q & 32'hf4, 32'hd0);
    wb(`FCPS_ADR_DIVIDER, 1'b1, 32'h05); // divider set before any program
    wb(`FCPS_ADR_STATUS, 1'b1, 32'h00);
    launch(`FCPS_CMD_BYTE, 16'hf000);
    wait_done;
    chk(q & 32'hf4, 32'hd0);
    chk(n_busy, n0);
    wb(`FCPS_ADR_STATUS, 1'b1, 32'h30);
    // shrink refused, lane-0-less write ignored, grow accepted
    wb(`FCPS_ADR_PROT, 1'b1, 32'h0a);
    sel <= 4'h0;
    wb(`FCPS_ADR_PROT, 1'b1, 32'h04);
    sel <= 4'hf;
    wb(`FCPS_ADR_PROT, 1'b0, 32'h0);
    chk(q, 32'h06);
    wb(`FCPS_ADR_PROT, 1'b1, 32'h04);
    wb(`FCPS_ADR_PROT, 1'b0, 32'h0);
    chk(q, 32'h04);
    launch(`FCPS_CMD_BYTE, 16'hf600);
    wait_done;
    chk(q & 32'hf4, 32'he0);
    chk(n_busy, n0);
    wb(`FCPS_ADR_STATUS, 1'b1, 32'h20);
    launch(`FCPS_CMD_BYTE, 16'hf5ff);
    wait_done;
    chk(q & 32'hf4, 32'hc0);
    chk(last_cmd, `FCPS_CMD_BYTE);
    chk(aaddr, 16'hf5ff);
    chk(adat, 8'h5a);
    // debug port disables protection, then all bits writable
    dbg_d <= 8'h01;
    dbg_we <= 1'b1;
    @(posedge clk);
    dbg_we <= 1'b0;
    wb(`FCPS_ADR_PROT, 1'b0, 32'h0);
    chk(q, 32'h01);
    wb(`FCPS_ADR_PROT, 1'b1, 32'hfd);
    wb(`FCPS_ADR_PROT, 1'b0, 32'h0);
    chk(q, 32'hfd);
    // key window with key writes enabled, then as a command
    wb(`FCPS_ADR_CONFIG, 1'b1, 32'h20);
    wb(`FCPS_ADR_CONFIG, 1'b0, 32'h0);
    chk(q, 32'h20);
    wb(`FCPS_ADR_KEY, 1'b1, {8'h00, `FCPS_KEY_BASE, 8'h11});
    wb(`FCPS_ADR_COMMAND, 1'b1, {24'h0, `FCPS_CMD_BYTE});
    wb(`FCPS_ADR_STATUS, 1'b1, 32'h80);
    wait_done;
    chk(q & 32'h10, 32'h10);
    wb(`FCPS_ADR_STATUS, 1'b1, 32'h30);
    wb(`FCPS_ADR_CONFIG, 1'b1, 32'h00);
    launch(`FCPS_CMD_BYTE, `FCPS_KEY_BASE);
    wait_done;
    chk(q & 32'hf4, 32'hc0);
    // command table
    for (i = 0; i < 7; i++) begin
      blank <= rows[i].bl;
      launch(rows[i].code, 16'hf000);
      wait_done;
      chk(q & 32'hf4, rows[i].st);
      chk(sec, rows[i].sc); // a blank check of a blank array unlocks and sets the blank flag
      if (rows[i].st[4] == 1'b0) chk(last_cmd, rows[i].code);
      wb(`FCPS_ADR_STATUS, 1'b1, 32'h30);
    end
    // stop entry during a running erase
    launch(`FCPS_CMD_MASS, 16'hf000);
    wb(`FCPS_ADR_STATUS, 1'b0, 32'h0);
    chk(q[`FCPS_ST_CCF], 1'b0);
    chk(busy, 1'b1);
    stop <= 1'b1;
    wait_done;
    stop <= 1'b0;
    chk(q & 32'h10, 32'h10);
    wb(6'h3c, 1'b0, 32'h0);
    chk(q, 32'h0);
    end_sim;
  end
endmodule // fcps_flash_ctrl_tb
